// ### pkg/rtc_regs.svh
// rtc register map, field positions, reset values and cycle figures
// assumes a 32-bit classic wishbone slave with 16-bit registers in bits 15:0
// Operation
// - 32-bit counter counts time-base ticks
// - 20-bit divider derives tick from rtc clock
// - tick period programmable up to one second
// - seconds interrupt once per tick when enabled
// - alarm interrupt when counter equals alarm
// - software loads counter, counting continues from it
// - rtc clock: fast ext/128, slow ext, slow int
// - 16-bit registers over bus; stat and div read-only, clr write-only
// - bus side on bus clock, core synchronised
// - system reset clears interface and control register
// - core cleared only by backup-domain reset
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// word indices, byte address is four times the index
`define RTC_IDX_CTRL 4'h0
`define RTC_IDX_STAT 4'h1
`define RTC_IDX_CLR 4'h2
`define RTC_IDX_CFG 4'h3
`define RTC_IDX_PSC_HI 4'h4
`define RTC_IDX_PSC_LO 4'h5
`define RTC_IDX_DIV_HI 4'h6
`define RTC_IDX_DIV_LO 4'h7
`define RTC_IDX_CNT_HI 4'h8
`define RTC_IDX_CNT_LO 4'h9
`define RTC_IDX_ALM_HI 4'ha
`define RTC_IDX_ALM_LO 4'hb

// reset values
`define RTC_CTRL_RST 3'h0
`define RTC_STAT_RST 3'h0
`define RTC_PSC_RST 20'h07fff
`define RTC_CNT_RST 32'h0000_0000
`define RTC_ALM_RST 32'h0000_0000
`define RTC_DIV_ZERO 20'h00000
`define RTC_CNT_ONES 32'hffff_ffff
`define RTC_CNT_STEP 32'h0000_0001
`define RTC_DIV_STEP 20'h00001
`define RTC_HI_PAD 16'h0000
`define RTC_PSC_PAD 12'h000
`define RTC_FLAG_PAD 13'h0000
`define RTC_SRC_PAD 14'h0000

// high-speed oscillator predivide: one pulse per 128 rising edges
`define RTC_HSE_LAST 7'h7f
`define RTC_HSE_RST 7'h00
`define RTC_HSE_STEP 7'h01

`endif

// ### pkg/rtc_pkg.sv
// rtc shared types: interrupt flags, clock source codes, bus write request
// assumes the map constants of rtc_regs.svh
package rtc_pkg;

    typedef logic [15:0] rtc_half_t;

    // bit 0 seconds, bit 1 alarm, bit 2 overflow
    typedef struct packed {
        logic ovf;
        logic alarm;
        logic sec;
    } rtc_flags_t;

    typedef enum logic [1:0] {
        RTC_SRC_HSE = 2'h0,
        RTC_SRC_LSE = 2'h1,
        RTC_SRC_LSI = 2'h2
    } rtc_src_t;

    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [1:0] sel;
        rtc_half_t dat;
    } rtc_wreq_t;

endpackage

// ### rtl/rtc_top.sv
// rtc core with prescaler, 32-bit counter, alarm compare and interrupt flags
// assumes a classic wishbone master, oscillator inputs synchronous to clk_i
// and toggling no faster than a quarter of clk_i
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bkp_rst_i,
    input wire logic ce_i,
    input wire logic backup_write_unlock_i,
    input wire logic hse_osc_i,
    input wire logic lse_osc_i,
    input wire logic lsi_osc_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic time_base_tick_o
);

    // byte-lane merge of a 16-bit register half
    function automatic rtc_pkg::rtc_half_t merge(
        input rtc_pkg::rtc_half_t old_v,
        input rtc_pkg::rtc_half_t new_v,
        input logic [1:0] sel
    );
        merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                 sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // bus-domain state, cleared by system reset
    logic [2:0] ctrl_en;
    rtc_pkg::rtc_flags_t stat;
    // core state, cleared only by backup reset
    rtc_pkg::rtc_src_t src;
    logic [19:0] reload;
    logic [19:0] div;
    logic [31:0] cnt;
    logic [31:0] alm;
    logic [6:0] hse_cnt;
    logic hse_prev;
    logic lse_prev;
    logic lsi_prev;

    // request carrier
    rtc_pkg::rtc_wreq_t req;
    assign req = '{we: wb_we_i, idx: wb_adr_i[5:2], sel: wb_sel_i[1:0],
                   dat: wb_dat_i[15:0]};

    // one answer per request; the ack term keeps a held request single
    wire bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land at the edge that samples ack, where the master sees them
    wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & req.we;
    // core writes need the backup unlock, otherwise silently dropped
    wire core_wr = wr & backup_write_unlock_i;
    wire wr_ctrl = wr && (req.idx == `RTC_IDX_CTRL);
    wire wr_clr = wr && (req.idx == `RTC_IDX_CLR);
    wire wr_cfg = core_wr && (req.idx == `RTC_IDX_CFG);
    wire wr_psc_hi = core_wr && (req.idx == `RTC_IDX_PSC_HI);
    wire wr_psc_lo = core_wr && (req.idx == `RTC_IDX_PSC_LO);
    wire wr_cnt_hi = core_wr && (req.idx == `RTC_IDX_CNT_HI);
    wire wr_cnt_lo = core_wr && (req.idx == `RTC_IDX_CNT_LO);
    wire wr_alm_hi = core_wr && (req.idx == `RTC_IDX_ALM_HI);
    wire wr_alm_lo = core_wr && (req.idx == `RTC_IDX_ALM_LO);
    wire psc_wr = wr_psc_hi | wr_psc_lo;
    wire cnt_wr = wr_cnt_hi | wr_cnt_lo;

    // oscillator edge detection; inputs are already in the clk_i domain,
    // and the quarter-rate limit guarantees every edge is seen
    wire hse_rise = hse_osc_i & ~hse_prev;
    wire lse_rise = lse_osc_i & ~lse_prev;
    wire lsi_rise = lsi_osc_i & ~lsi_prev;
    wire hse_div_rise = hse_rise && (hse_cnt == `RTC_HSE_LAST);
    wire [6:0] next_hse_cnt = hse_rise ? hse_cnt + `RTC_HSE_STEP : hse_cnt;

    // clock source select; the core advances on enables, not on a clock
    wire rtc_edge = (src == rtc_pkg::RTC_SRC_HSE) ? hse_div_rise :
                    (src == rtc_pkg::RTC_SRC_LSE) ? lse_rise :
                    (src == rtc_pkg::RTC_SRC_LSI) ? lsi_rise : 1'b0;

    // prescaler: count down, tick and reload at zero, factor reload+1
    wire div_zero = (div == `RTC_DIV_ZERO);
    wire tick = ce_i & rtc_edge & div_zero;
    // merged halves as named wires, a call result cannot be part-selected
    wire [15:0] psc_hi_m = merge({`RTC_PSC_PAD, reload[19:16]}, req.dat, req.sel);
    wire [19:0] next_reload = wr_psc_hi ?
        {psc_hi_m[3:0], reload[15:0]} :
        wr_psc_lo ? {reload[19:16], merge(reload[15:0], req.dat, req.sel)} :
        reload;
    // a new prescale restarts the divider so the first period is whole
    wire [19:0] next_div = psc_wr ? next_reload :
                           (rtc_edge && div_zero) ? reload :
                           rtc_edge ? div - `RTC_DIV_STEP : div;

    // counter: a software load wins over a tick in the same cycle
    wire [31:0] cnt_inc = cnt + `RTC_CNT_STEP;
    wire [31:0] next_cnt = wr_cnt_hi ?
        {merge(cnt[31:16], req.dat, req.sel), cnt[15:0]} :
        wr_cnt_lo ? {cnt[31:16], merge(cnt[15:0], req.dat, req.sel)} :
        tick ? cnt_inc : cnt;
    wire [31:0] next_alm = wr_alm_hi ?
        {merge(alm[31:16], req.dat, req.sel), alm[15:0]} :
        wr_alm_lo ? {alm[31:16], merge(alm[15:0], req.dat, req.sel)} : alm;
    wire [15:0] src_m = merge({`RTC_SRC_PAD, src}, req.dat, req.sel);
    wire [1:0] src_code = src_m[1:0];

    // events
    wire ev_alarm = tick & ~cnt_wr & (cnt_inc == alm);
    wire ev_ovf = tick & ~cnt_wr & (cnt == `RTC_CNT_ONES);
    rtc_pkg::rtc_flags_t ev;
    assign ev = '{ovf: ev_ovf, alarm: ev_alarm, sec: tick};

    // sticky flags: set wins over a clear in the same cycle
    wire [2:0] clr_mask = wr_clr ? (wb_dat_i[2:0] & {3{req.sel[0]}}) :
                          `RTC_STAT_RST;
    rtc_pkg::rtc_flags_t next_stat;
    assign next_stat = (stat & ~clr_mask) | ev;
    wire [15:0] ctrl_m = merge({`RTC_FLAG_PAD, ctrl_en}, req.dat, req.sel);
    wire [2:0] next_ctrl = wr_ctrl ? ctrl_m[2:0] : ctrl_en;
    wire irq_now = |(stat & ctrl_en);

    // read selection, unmapped and write-only words read zero
    wire [15:0] rdata =
        (req.idx == `RTC_IDX_CTRL) ? {`RTC_FLAG_PAD, ctrl_en} :
        (req.idx == `RTC_IDX_STAT) ? {`RTC_FLAG_PAD, stat} :
        (req.idx == `RTC_IDX_CFG) ? {`RTC_SRC_PAD, src} :
        (req.idx == `RTC_IDX_PSC_HI) ? {`RTC_PSC_PAD, reload[19:16]} :
        (req.idx == `RTC_IDX_PSC_LO) ? reload[15:0] :
        (req.idx == `RTC_IDX_DIV_HI) ? {`RTC_PSC_PAD, div[19:16]} :
        (req.idx == `RTC_IDX_DIV_LO) ? div[15:0] :
        (req.idx == `RTC_IDX_CNT_HI) ? cnt[31:16] :
        (req.idx == `RTC_IDX_CNT_LO) ? cnt[15:0] :
        (req.idx == `RTC_IDX_ALM_HI) ? alm[31:16] :
        (req.idx == `RTC_IDX_ALM_LO) ? alm[15:0] : `RTC_HI_PAD;

    // bus slave: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {`RTC_HI_PAD, `RTC_HI_PAD};
        end else if (ce_i) begin
            wb_ack_o <= bus_hit;
            if (bus_hit) begin
                wb_dat_o <= {`RTC_HI_PAD, rdata};
            end
        end
    end

    // control and interrupt state on the system reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_en <= `RTC_CTRL_RST;
            stat <= `RTC_STAT_RST;
            irq_o <= 1'b0;
            time_base_tick_o <= 1'b0;
        end else if (ce_i) begin
            ctrl_en <= next_ctrl;
            stat <= next_stat;
            irq_o <= irq_now;
            time_base_tick_o <= tick;
        end
    end

    // core keeps time across system reset; only backup reset clears it
    always_ff @(posedge clk_i) begin
        if (bkp_rst_i) begin
            src <= rtc_pkg::RTC_SRC_HSE;
            reload <= `RTC_PSC_RST;
            div <= `RTC_PSC_RST;
            cnt <= `RTC_CNT_RST;
            alm <= `RTC_ALM_RST;
        end else if (ce_i) begin
            if (wr_cfg) begin
                src <= rtc_pkg::rtc_src_t'(src_code);
            end
            reload <= next_reload;
            div <= next_div;
            cnt <= next_cnt;
            alm <= next_alm;
        end
    end

    // oscillator history; the previous level must survive system reset
    always_ff @(posedge clk_i) begin
        if (bkp_rst_i) begin
            hse_cnt <= `RTC_HSE_RST;
            hse_prev <= 1'b0;
            lse_prev <= 1'b0;
            lsi_prev <= 1'b0;
        end else if (ce_i) begin
            hse_cnt <= next_hse_cnt;
            hse_prev <= hse_osc_i;
            lse_prev <= lse_osc_i;
            lsi_prev <= lsi_osc_i;
        end
    end

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || bkp_rst_i);

    // one-cycle ack per request
    ack_answer_a: assert property (
        (bus_hit && ce_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");

    // counter steps by one per tick
    cnt_step_a: assert property (
        (tick && !cnt_wr) |=> (cnt == $past(cnt_inc)))
        else $error("counter did not increment on tick");

    // divider reloads at tick
    div_reload_a: assert property (
        (tick && !psc_wr) |=> (div == $past(reload)))
        else $error("divider did not reload at tick");

    // seconds flag set by tick even when cleared the same cycle
    sec_flag_a: assert property (
        tick |=> stat.sec)
        else $error("seconds flag not set on tick");

    // alarm flag on compare match
    alarm_hit_a: assert property (
        (tick && !cnt_wr && (cnt_inc == alm)) |=> (stat.alarm && cnt == alm))
        else $error("alarm flag missed on compare match");

    // overflow on wrap to zero
    ovf_wrap_a: assert property (
        (tick && !cnt_wr && (cnt == `RTC_CNT_ONES)) |=>
            (stat.ovf && cnt == `RTC_CNT_RST))
        else $error("overflow not flagged on wrap");

    // interrupt follows enabled flags one cycle later
    irq_level_a: assert property (
        ce_i |=> (irq_o == $past(irq_now)))
        else $error("interrupt output does not track enabled flags");

    // clock enable low freezes the core and flags
    freeze_all_a: assert property (
        !ce_i |=> ($stable(cnt) && $stable(stat) && $stable(div)))
        else $error("state moved while clock enable low");

    // locked backup domain ignores counter writes
    write_lock_a: assert property (
        (wr && !backup_write_unlock_i && !tick &&
         (req.idx == `RTC_IDX_CNT_LO)) |=> $stable(cnt))
        else $error("counter written while backup locked");

    // low-half load with both byte lanes lands in the counter next cycle
    cnt_load_a: assert property (
        (wr_cnt_lo && ce_i && req.sel == 2'h3) |=>
            (cnt[15:0] == $past(wb_dat_i[15:0])))
        else $error("counter load value not taken");

    // backup reset clears the core
    bkp_clear_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        bkp_rst_i |=> (cnt == `RTC_CNT_RST && alm == `RTC_ALM_RST))
        else $error("core not cleared by backup reset");

    // system reset clears control and irq but leaves the alarm alone
    sys_reset_a: assert property (
        @(posedge clk_i) disable iff (bkp_rst_i)
        rst_i |=> (ctrl_en == `RTC_CTRL_RST && !irq_o && $stable(alm)))
        else $error("system reset behaviour wrong");

endmodule

`default_nettype wire

// ### verif/rtc_osc_model.sv
// oscillator model: three free-running source levels for the rtc block
// assumes clk_i is the bus clock; levels change only after its rising edges
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(
    parameter int HSE_HALF = 2,
    parameter int LSE_HALF = 4,
    parameter int LSI_HALF = 6
) (
    input wire logic clk_i,
    output wire logic hse_o,
    output wire logic lse_o,
    output wire logic lsi_o
);
    int cnt = 0;
    // each level lasts at least two cycles, so no source beats a quarter of clk_i
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
    end
    // three independent sources for the selector to pick from
    assign hse_o = ((cnt / HSE_HALF) % 2) == 1;
    assign lse_o = ((cnt / LSE_HALF) % 2) == 1;
    assign lsi_o = ((cnt / LSI_HALF) % 2) == 1;
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the rtc block: bus access, ticks, flags, resets
// assumes the map of rtc_regs.svh and the oscillator model beside it
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bkp_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic unlock = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    wire logic [31:0] dat_o;
    wire logic ack, irq, tick, high_speed_ext_osc, low_speed_ext_osc, low_speed_int_osc;
    int bad_count = 0;
    int comparisons = 0;
    int n;
    int per[3] = '{1024, 16, 24};

    rtc_osc_model osc (.clk_i(clk_i), .hse_o(high_speed_ext_osc), .lse_o(low_speed_ext_osc), .lsi_o(low_speed_int_osc));
    rtc_top dut (.clk_i(clk_i), .rst_i(rst_i), .bkp_rst_i(bkp_rst_i), .ce_i(ce_i),
        .backup_write_unlock_i(unlock), .hse_osc_i(high_speed_ext_osc), .lse_osc_i(low_speed_ext_osc),
        .lsi_osc_i(low_speed_int_osc), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .irq_o(irq), .time_base_tick_o(tick));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request stands until ack is sampled high; read data taken at that edge
    task automatic bus(input logic w, input logic [3:0] idx, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 100);
        rdat = dat_o;
        if (k >= 100) bad_count++;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(what, rdat, exp);
    endtask

    // returns the number of clock edges from the call to the next tick pulse
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (tick !== 1'b1 && k < 3000);
        if (k >= 3000) bad_count++;
    endtask

    task automatic t_reset();
        rd("ctrl", `RTC_IDX_CTRL, 32'h00000000);
        rd("stat", `RTC_IDX_STAT, 32'h00000000);
        rd("psc lo", `RTC_IDX_PSC_LO, 32'h00007fff);
        rd("cnt lo", `RTC_IDX_CNT_LO, 32'h00000000);
        rd("unmapped", 4'hc, 32'h00000000);
        bus(1'b1, `RTC_IDX_CFG, 16'h0002);
        rd("cfg locked", `RTC_IDX_CFG, 32'h00000000);
        bus(1'b1, `RTC_IDX_CNT_LO, 16'h5555);
        rd("cnt locked", `RTC_IDX_CNT_LO, 32'h00000000);
    endtask

    task automatic t_source();
        unlock <= 1'b1;
        bus(1'b1, `RTC_IDX_PSC_HI, 16'hffff);
        rd("psc hi", `RTC_IDX_PSC_HI, 32'h0000000f);
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, `RTC_IDX_CFG, 16'(s));
            bus(1'b1, `RTC_IDX_PSC_HI, 16'h0000);
            bus(1'b1, `RTC_IDX_PSC_LO, 16'h0001);
            wait_tick(n);
            wait_tick(n);
            chk("tick period", n, per[s]);
        end
    endtask

    task automatic t_count();
        bus(1'b1, `RTC_IDX_CFG, 16'h0001);
        bus(1'b1, `RTC_IDX_PSC_LO, 16'h0003);
        wait_tick(n);
        bus(1'b1, `RTC_IDX_CNT_HI, 16'h00ab);
        bus(1'b1, `RTC_IDX_CNT_LO, 16'h1234);
        repeat (3) wait_tick(n);
        rd("cnt lo", `RTC_IDX_CNT_LO, 32'h00001237);
        rd("cnt hi", `RTC_IDX_CNT_HI, 32'h000000ab);
        // one more tick, then a long freeze that must not add any
        wait_tick(n);
        ce_i <= 1'b0;
        repeat (200) @(posedge clk_i);
        ce_i <= 1'b1;
        rd("cnt frozen", `RTC_IDX_CNT_LO, 32'h00001238);
    endtask

    task automatic t_irq();
        bus(1'b1, `RTC_IDX_CTRL, 16'h0000);
        wait_tick(n);
        repeat (2) @(posedge clk_i);
        chk("irq masked", irq, 1'b0);
        rd("stat sec", `RTC_IDX_STAT, 32'h00000001);
        bus(1'b1, `RTC_IDX_CTRL, 16'h0001);
        bus(1'b1, `RTC_IDX_CLR, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", irq, 1'b0);
        wait_tick(n);
        repeat (2) @(posedge clk_i);
        chk("irq sec", irq, 1'b1);
    endtask

    task automatic t_wrap();
        bus(1'b1, `RTC_IDX_CTRL, 16'h0006);
        bus(1'b1, `RTC_IDX_ALM_HI, 16'h0000);
        bus(1'b1, `RTC_IDX_ALM_LO, 16'h0001);
        wait_tick(n);
        bus(1'b1, `RTC_IDX_CNT_HI, 16'hffff);
        bus(1'b1, `RTC_IDX_CNT_LO, 16'hfffe);
        bus(1'b1, `RTC_IDX_CLR, 16'h0007);
        repeat (2) @(posedge clk_i);
        chk("irq idle", irq, 1'b0);
        repeat (2) wait_tick(n);
        repeat (2) @(posedge clk_i);
        chk("irq ovf", irq, 1'b1);
        rd("stat ovf", `RTC_IDX_STAT, 32'h00000005);
        rd("cnt hi", `RTC_IDX_CNT_HI, 32'h00000000);
        bus(1'b1, `RTC_IDX_CLR, 16'h0007);
        wait_tick(n);
        repeat (2) @(posedge clk_i);
        chk("irq alarm", irq, 1'b1);
        rd("stat alarm", `RTC_IDX_STAT, 32'h00000003);
    endtask

    task automatic t_resets();
        bus(1'b1, `RTC_IDX_CTRL, 16'h0007);
        bus(1'b1, `RTC_IDX_CNT_HI, 16'h5a5a);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", `RTC_IDX_CTRL, 32'h00000000);
        rd("cnt hi kept", `RTC_IDX_CNT_HI, 32'h00005a5a);
        rd("psc kept", `RTC_IDX_PSC_LO, 32'h00000003);
        @(posedge clk_i);
        bkp_rst_i <= 1'b1;
        @(posedge clk_i);
        bkp_rst_i <= 1'b0;
        rd("cnt hi", `RTC_IDX_CNT_HI, 32'h00000000);
        rd("psc lo", `RTC_IDX_PSC_LO, 32'h00007fff);
        rd("alm lo", `RTC_IDX_ALM_LO, 32'h00000000);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bkp_rst_i <= 1'b0;
        t_reset();
        t_source();
        t_count();
        t_irq();
        t_wrap();
        t_resets();
        summarize();
    end

    // the source sweep needs up to about 2200 cycles, the rest a few hundred
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
